/* hdl/cssr_spi_shift.sv */
// serial interface frame shifter: 8-bit header, 16-bit data, msb first
`timescale 1ns/1ps
`default_nettype none
`include "cssr_map.svh"

module cssr_spi_shift
  import cssr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        spiSclk,
  input  wire logic        spiCsB,
  input  wire logic        spiMosi,
  input  wire logic [15:0] rdData,
  output logic      [6:0]  rdAddr,
  output logic             spiMiso,
  output logic             spiMisoOeB,
  output cssr_frame_t      frame,
  output logic             frameValid
);

  cssr_spi_state_t state_ff, nxt_state;
  logic        sclkPrev_ff;
  logic        csPrev_ff;
  logic [4:0]  bitCnt_ff;
  logic [7:0]  headShift_ff;
  logic [15:0] wrShift_ff;
  logic [15:0] rdShift_ff;
  logic        loadRd_ff;
  logic        miso_ff;
  logic        misoOeB_ff;
  cssr_frame_t frame_ff;
  logic        frameValid_ff;

  // sclk is sampled as a plain input; host keeps it well below clk_sys/4
  wire sclkRise   = spiSclk & ~sclkPrev_ff;
  wire sclkFall   = ~spiSclk & sclkPrev_ff;
  // a frame starts on a chip select fall; csPrev_ff resets high, so a reset mid-frame restarts the header at once
  wire csFall     = ~spiCsB & csPrev_ff;
  wire headDone   = (state_ff == CSSR_HEAD) & sclkRise & (bitCnt_ff == `CSSR_HEAD_BITS - 5'h01);
  wire frameDone  = (state_ff == CSSR_DATA) & sclkRise & (bitCnt_ff == `CSSR_FRAME_BITS - 5'h01);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      CSSR_IDLE: if (csFall) nxt_state = CSSR_HEAD;
      CSSR_HEAD: if (spiCsB) nxt_state = CSSR_IDLE; else if (headDone) nxt_state = CSSR_DATA;
      CSSR_DATA: if (spiCsB || frameDone) nxt_state = CSSR_IDLE;
      default:   nxt_state = CSSR_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_ff      <= CSSR_IDLE;
      sclkPrev_ff   <= 1'b0;
      csPrev_ff     <= 1'b1;
      bitCnt_ff     <= 5'h00;
      headShift_ff  <= 8'h00;
      wrShift_ff    <= 16'h0000;
      rdShift_ff    <= 16'h0000;
      loadRd_ff     <= 1'b0;
      miso_ff       <= 1'b0;
      misoOeB_ff    <= 1'b1;
      frame_ff      <= '0;
      frameValid_ff <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      sclkPrev_ff   <= spiSclk;
      csPrev_ff     <= spiCsB;
      loadRd_ff     <= headDone;
      frameValid_ff <= frameDone;
      misoOeB_ff    <= ~(state_ff == CSSR_DATA);
      if (csFall) bitCnt_ff <= 5'h00;
      else if (sclkRise) bitCnt_ff <= bitCnt_ff + 5'h01;
      if (sclkRise && state_ff == CSSR_HEAD) headShift_ff <= {headShift_ff[6:0], spiMosi};
      if (sclkRise && state_ff == CSSR_DATA) wrShift_ff <= {wrShift_ff[14:0], spiMosi};
      if (loadRd_ff) rdShift_ff <= rdData;
      else if (sclkFall && state_ff == CSSR_DATA) rdShift_ff <= {rdShift_ff[14:0], 1'b0};
      if (sclkFall && state_ff == CSSR_DATA) miso_ff <= rdShift_ff[15];
      if (frameDone) frame_ff <= '{write: headShift_ff[7], addr: headShift_ff[6:0],
                                   data: {wrShift_ff[14:0], spiMosi}};
    end
  end

  assign rdAddr     = headShift_ff[6:0];
  assign spiMiso    = miso_ff;
  assign spiMisoOeB = misoOeB_ff;
  assign frame      = frame_ff;
  assign frameValid = frameValid_ff;

endmodule
`default_nettype wire

/* hdl/cssr_top.sv */
// core activity status and software reset registers behind the serial interface
`timescale 1ns/1ps
`default_nettype none
`include "cssr_map.svh"

// Behaviour
// [R1] read-only 16-bit status at 0x02, four bits
// [R2] bits 0-3 flag cores A-D active, default 1111
// [R3] reset trigger register at 0x04, zero does nothing
// [R4] writing one resets all configuration and flip-flops; swRstTrig_ff and cfgRstB_ff are reset only by the pin
// [R5] trigger clears itself; host need not write zero
module cssr_top
  import cssr_pkg::*;
#(
  parameter int CORES = `CSSR_CORE_CNT
)
(
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             spiSclk,
  input  wire logic             spiCsB,
  input  wire logic             spiMosi,
  input  wire logic [CORES-1:0] coreStandbyReq,
  output logic                  spiMiso,
  output logic                  spiMisoOeB,
  output logic      [CORES-1:0] coreActive,
  output logic                  cfgRstB
);

  logic             swRstTrig_ff;
  logic [CORES-1:0] coreActive_ff;
  logic             cfgRstB_ff;
  logic [6:0]       rdAddr;
  cssr_frame_t      frame;
  logic             frameValid;

  function automatic logic hitAddr(input logic [6:0] a, input logic [6:0] reg_addr);
    hitAddr = (a == reg_addr);
  endfunction

  // the shifter and the core flags fall under the soft reset; the trigger and cfgRstB_ff do not
  wire localRstB   = rst_b & ~swRstTrig_ff; // [R4]
  wire swRstWrite  = frameValid & frame.write & hitAddr(frame.addr, `CSSR_SRST_ADDR)
                     & frame.data[`CSSR_SRST_BIT]; // [R3]
  wire [15:0] statusWord = {{(16-CORES){1'b0}}, coreActive_ff}; // [R1]
  // the trigger is never seen as set: a read of the register returns the constant CSSR_SRST_RST
  wire        statusSel  = hitAddr(rdAddr, `CSSR_STATUS_ADDR); // [R1]
  wire        srstSel    = hitAddr(rdAddr, `CSSR_SRST_ADDR); // [R3]
  wire [15:0] rdData     = statusSel ? statusWord : srstSel ? `CSSR_SRST_RST : 16'h0000; // [R1]

  cssr_spi_shift u_shift (
    .clk_sys    (clk_sys),
    .rst_b      (localRstB),
    .spiSclk    (spiSclk),
    .spiCsB     (spiCsB),
    .spiMosi    (spiMosi),
    .rdData     (rdData),
    .rdAddr     (rdAddr),
    .spiMiso    (spiMiso),
    .spiMisoOeB (spiMisoOeB),
    .frame      (frame),
    .frameValid (frameValid)
  );

  // trigger is reset only by the pin, so it always drops after one clock
  always_ff @(posedge clk_sys) begin
    if (!rst_b) swRstTrig_ff <= 1'b0;
    else        swRstTrig_ff <= swRstWrite; // [R5]
  end

  // status writes are ignored; the register is read only
  always_ff @(posedge clk_sys) begin
    if (!localRstB) coreActive_ff <= `CSSR_FLAGS_RST; // [R2]
    else            coreActive_ff <= ~coreStandbyReq; // [R2]
  end

  // registered reset out to the other configuration registers of the device
  always_ff @(posedge clk_sys) begin
    if (!rst_b) cfgRstB_ff <= 1'b0;
    else        cfgRstB_ff <= ~swRstWrite; // [R4]
  end

  assign coreActive = coreActive_ff;
  assign cfgRstB    = cfgRstB_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  status_upper_zero_a: assert property (hitAddr(rdAddr, `CSSR_STATUS_ADDR) |-> rdData[15:4] == 12'h000) // [R1]
    else $error("status upper bits not zero");
  status_read_flags_a: assert property (hitAddr(rdAddr, `CSSR_STATUS_ADDR) |-> rdData[3:0] == coreActive) // [R1]
    else $error("status read does not show core flags");
  flags_follow_standby_a: assert property (swRstTrig_ff == 1'b0 |=> coreActive == ~$past(coreStandbyReq)) // [R2]
    else $error("core flags do not follow standby");
  flags_reset_active_a: assert property (swRstTrig_ff |=> coreActive == 4'hf) // [R2]
    else $error("core flags not all active after soft reset");
  zero_write_idle_a: assert property (frameValid && frame.write && hitAddr(frame.addr, `CSSR_SRST_ADDR) // [R3]
                                      && !frame.data[`CSSR_SRST_BIT] |=> !swRstTrig_ff && cfgRstB)
    else $error("writing zero caused a reset");
  one_write_resets_a: assert property (frameValid && frame.write && hitAddr(frame.addr, `CSSR_SRST_ADDR) // [R4]
                                       && frame.data[`CSSR_SRST_BIT] |=> swRstTrig_ff && !cfgRstB)
    else $error("writing one did not reset");
  reset_reaches_shift_a: assert property (swRstTrig_ff |=> spiMisoOeB && !frameValid) // [R4]
    else $error("shifter not reset by soft reset");
  trigger_self_clear_a: assert property (swRstTrig_ff |=> !swRstTrig_ff ##1 cfgRstB) // [R5]
    else $error("trigger did not clear itself");
  srst_reads_zero_a: assert property (srstSel |-> rdData == `CSSR_SRST_RST) // [R3]
    else $error("reset trigger register does not read as zero");
  trigger_needs_one_a: assert property (swRstTrig_ff |-> $past(swRstWrite)) // [R3]
    else $error("reset trigger set without a write of one");
  // the pin reset also holds the output low, so only count lows that follow a released pin
  cfg_low_needs_one_a: assert property ($past(rst_b) && !cfgRstB |-> $past(swRstWrite)) // [R4]
    else $error("configuration reset without a write of one");
  cfg_pulse_single_a: assert property (!cfgRstB |=> cfgRstB) // [R5]
    else $error("configuration reset held longer than one clock");
  oe_idle_released_a: assert property (spiCsB ##1 spiCsB ##1 spiCsB |-> spiMisoOeB) // [R1]
    else $error("data line still driven after chip select rose");
  // the pin reset itself is watched here, so this one must not be disabled by it
  pin_reset_flags_a: assert property (@(posedge clk_sys) disable iff (1'b0) // [R2]
                                      !rst_b |=> coreActive == 4'hf && !cfgRstB)
    else $error("flags not all active during pin reset");

  // each flag follows only its own core, so a swapped wire shows here
  for (genvar c = 0; c < CORES; c++) begin : g_core_chk
    core_flag_own_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R2]
                                      !swRstTrig_ff |=> coreActive[c] == !$past(coreStandbyReq[c]))
      else $error("core flag does not follow its own standby input");
    status_bit_own_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R2]
                                       statusSel |-> rdData[c] == coreActive[c])
      else $error("status bit not mapped to its core");
  end

  soft_reset_c: cover property (swRstWrite ##1 swRstTrig_ff ##1 !swRstTrig_ff);
  status_read_c: cover property (hitAddr(rdAddr, `CSSR_STATUS_ADDR) && !spiMisoOeB);
  core_standby_c: cover property (coreActive != 4'hf);
  zero_write_c: cover property (frameValid && frame.write && hitAddr(frame.addr, `CSSR_SRST_ADDR)
                                && !frame.data[`CSSR_SRST_BIT]);
  status_write_c: cover property (frameValid && frame.write && hitAddr(frame.addr, `CSSR_STATUS_ADDR));

endmodule
`default_nettype wire

/* include/cssr_map.svh */
// register offsets, field positions, reset values and frame counts of the status and soft reset bank
`ifndef CSSR_MAP_SVH
`define CSSR_MAP_SVH

`define CSSR_ADDR_W           7
`define CSSR_DATA_W           16
`define CSSR_STATUS_ADDR      7'h02
`define CSSR_SRST_ADDR        7'h04
`define CSSR_STATUS_RST       16'h000f
`define CSSR_SRST_RST         16'h0000
`define CSSR_CORE_CNT         4
`define CSSR_FLAGS_RST        4'hf
`define CSSR_SRST_BIT         0
`define CSSR_HEAD_BITS        5'h08
`define CSSR_DATA_BITS        5'h10
`define CSSR_FRAME_BITS       5'h18

`endif

/* include/cssr_pkg.sv */
// types shared by the status and soft reset bank
`default_nettype none
package cssr_pkg;

  typedef struct packed {
    logic        write;
    logic [6:0]  addr;
    logic [15:0] data;
  } cssr_frame_t;

  typedef enum logic [2:0] {
    CSSR_IDLE = 3'b001,
    CSSR_HEAD = 3'b010,
    CSSR_DATA = 3'b100
  } cssr_spi_state_t;

endpackage
`default_nettype wire

/* tb/cssr_host_model.sv */
// host controller model driving serial frames
`timescale 1ns/1ps
`default_nettype none
module cssr_host_model (
  input  wire logic clk_sys,
  input  wire logic spiMiso,
  output logic      spiSclk,
  output logic      spiCsB,
  output logic      spiMosi
);
  initial begin
    spiSclk = 1'b0;
    spiCsB  = 1'b1;
    spiMosi = 1'b0;
  end
  // sclk stays low outside frames; low phase long enough for synchronised miso
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [15:0] d, output logic [15:0] q);
    logic [23:0] w;
    w = {wr, a, d};
    @(posedge clk_sys) #2 spiCsB = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spiMosi = w[i];
      repeat (4) @(posedge clk_sys);
      #2 spiSclk = 1'b1;
      if (i < 16) q[i] = spiMiso;
      repeat (2) @(posedge clk_sys);
      #2 spiSclk = 1'b0;
    end
    repeat (2) @(posedge clk_sys);
    #2 spiCsB = 1'b1;
    spiMosi = ~spiMosi;
    repeat (3) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

/* tb/test_core_status_and_soft_reset.sv */
// randomized bench for the status and soft reset bank
`timescale 1ns/1ps
`default_nettype none
module test_core_status_and_soft_reset;
  import cssr_pkg::*;
  logic        clk_sys, rst_b, spiSclk, spiCsB, spiMosi, spiMiso, spiMisoOeB, cfgRstB, misoLine;
  logic [3:0]  coreStandbyReq, coreActive, actAfter;
  logic [15:0] q;
  int          error_cnt = 0, check_count = 0, lowCnt = 0;
  logic        prevLow = 1'b0;
  // released data line is pulled up
  assign misoLine = spiMisoOeB ? 1'b1 : spiMiso;
  cssr_top #(.CORES(4)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .spiSclk(spiSclk), .spiCsB(spiCsB),
    .spiMosi(spiMosi), .coreStandbyReq(coreStandbyReq), .spiMiso(spiMiso), .spiMisoOeB(spiMisoOeB),
    .coreActive(coreActive), .cfgRstB(cfgRstB));
  cssr_host_model host_u (.clk_sys(clk_sys), .spiMiso(misoLine), .spiSclk(spiSclk), .spiCsB(spiCsB),
    .spiMosi(spiMosi));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // counts low cycles of the config reset and keeps the flags seen one cycle later
  always @(negedge clk_sys) begin
    if (prevLow) actAfter = coreActive;
    prevLow = (rst_b === 1'b1) && (cfgRstB === 1'b0);
    if (prevLow) lowCnt++;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic logic [15:0] expStatus(input logic [3:0] req);
    return {12'h000, ~req};
  endfunction
  initial begin
    repeat (60000) @(posedge clk_sys);
    error_cnt++;
    summarize();
  end
  initial begin
    rst_b = 1'b0;
    coreStandbyReq = 4'h3;
    void'($urandom(32'h5034));
    repeat (4) @(posedge clk_sys);
    #2;
    chk({12'h000, coreActive}, 16'h000f);
    chk({15'h0000, cfgRstB}, 16'h0000);
    rst_b = 1'b1;
    repeat (2) @(posedge clk_sys);
    lowCnt = 0;
    $display("test reset done");
    for (int n = 0; n < 6; n++) begin
      @(posedge clk_sys) #2 coreStandbyReq = (n == 0) ? 4'hf : 4'($urandom);
      host_u.xfer(1'b0, 7'h02, 16'h0000, q);
      chk(q, expStatus(coreStandbyReq));
      host_u.xfer(1'b1, 7'h02, 16'($urandom), q);
      host_u.xfer(1'b0, 7'h02, 16'h0000, q);
      chk(q, expStatus(coreStandbyReq));
      host_u.xfer(1'b0, 7'h04, 16'h0000, q);
      chk(q, 16'h0000);
    end
    $display("test status done");
    for (int k = 0; k < 2; k++) begin
      host_u.xfer(1'b1, 7'h04, k ? 16'hfffe : 16'h0000, q);
    end
    repeat (6) @(posedge clk_sys);
    chk(16'(lowCnt), 16'h0000);
    $display("test zero trigger done");
    @(posedge clk_sys) #2 coreStandbyReq = 4'h5;
    // back-to-back triggers with no zero written between them
    for (int k = 1; k < 3; k++) begin
      host_u.xfer(1'b1, 7'h04, (k == 1) ? 16'h0001 : (16'($urandom) | 16'h0001), q);
      repeat (6) @(posedge clk_sys);
      chk(16'(lowCnt), 16'(k));
      chk({12'h000, actAfter}, 16'h000f);
      host_u.xfer(1'b0, 7'h02, 16'h0000, q);
      chk(q, expStatus(coreStandbyReq));
    end
    $display("test soft reset done");
    summarize();
  end
endmodule
`default_nettype wire
